// file: logic/bit_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] rst_val,
  output logic [WIDTH-1:0] sync_out
);

  // a chain of zero width has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("bit_sync width must be at least one");
  end

  logic [WIDTH-1:0] meta_r;

  // only the second stage leaves this module; both stages reset to the idle
  // level so that no false edge leaves the chain after reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= rst_val;
    end else begin
      meta_r <= async_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_out <= rst_val;
    end else begin
      sync_out <= meta_r;
    end
  end

endmodule

// file: logic/freq_status_pkg.sv
// constants shared by the reference rate status and range limit register bank
package freq_status_pkg;

  // ****************************************************************
  // register offsets on the serial configuration port
  // ****************************************************************
  localparam logic [6:0] REF_RATE_STATUS_A_OFS = 7'h10;
  localparam logic [6:0] REF_RATE_STATUS_B_OFS = 7'h11;
  localparam logic [6:0] REF_RATE_STATUS_C_OFS = 7'h12;
  localparam logic [6:0] SYNC_ZERO_RATE_STATUS_OFS = 7'h14;
  localparam logic [6:0] RANGE_LIMIT_CTRL_A_OFS = 7'h16;
  localparam logic [6:0] RANGE_LIMIT_CTRL_B_OFS = 7'h17;
  localparam logic [6:0] RANGE_LIMIT_CTRL_C_OFS = 7'h18;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int LOW_FIELD_LSB = 0;
  localparam int HIGH_FIELD_LSB = 4;
  localparam int SYNC_FAIL_BIT = 3;
  localparam logic [7:0] RANGE_LIMIT_CTRL_RST = 8'h33;
  localparam logic [7:0] UNMAPPED_READ_VAL = 8'h00;

  // ****************************************************************
  // serial frame layout
  // ****************************************************************
  localparam int CMD_READ_BIT = 7;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;

  // ****************************************************************
  // rate codes
  // ****************************************************************
  localparam logic [3:0] REF_RATE_2K = 4'h0;
  localparam logic [3:0] REF_RATE_77M76 = 4'hA;
  localparam logic [3:0] REF_RATE_UNKNOWN = 4'hF;
  localparam logic [2:0] SYNC_RATE_166HZ67 = 3'h0;
  localparam logic [2:0] SYNC_RATE_64K = 3'h7;
  localparam logic [2:0] SYNC_RATE_UNKNOWN = 3'h6;

  // ****************************************************************
  // out-of-range limit pairs in units of 0.1 ppm, indexed by select code
  // ****************************************************************
  localparam int OFS_W = 12;
  localparam logic [OFS_W-1:0] RANGE_UPPER [8] = '{
    12'h078, 12'h208, 12'h514, 12'h33E, 12'h0B4, 12'h140, 12'h1DB, 12'h2A3};
  localparam logic [OFS_W-1:0] RANGE_LOWER [8] = '{
    12'h05C, 12'h190, 12'h3E8, 12'h280, 12'h08A, 12'h0F6, 12'h16E, 12'h208};

  typedef enum logic [1:0] {spi_idle, spi_addr, spi_data} spi_state_t;

endpackage

// file: logic/range_monitor.sv
// out-of-range judgement with hysteresis for one reference
`timescale 1ns/100ps
module range_monitor
  import freq_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [OFS_W-1:0] offset_mag,
  input wire logic [2:0] limit_sel,
  output logic out_of_range_r
);

  logic [OFS_W-1:0] upper;
  logic [OFS_W-1:0] lower;

  // limit pair looked up from the select code
  always_comb begin
    upper = RANGE_UPPER[limit_sel];
    lower = RANGE_LOWER[limit_sel];
  end

  // hysteresis stops the flag chattering near one threshold
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_of_range_r <= 1'b0;
    end else if (offset_mag > upper) begin
      out_of_range_r <= 1'b1;
    end else if (offset_mag < lower) begin
      out_of_range_r <= 1'b0;
    end
  end

endmodule

// file: logic/ref_freq_detect_range_status.sv
// rate status and out-of-range limit registers behind the serial port
`timescale 1ns/100ps

module ref_freq_detect_range_status
  import freq_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic [3:0] input_zero_rate_code,
  input wire logic [3:0] input_one_rate_code,
  input wire logic [3:0] input_two_rate_code,
  input wire logic [3:0] input_three_rate_code,
  input wire logic [3:0] input_four_rate_code,
  input wire logic [4:0] ref_rate_known,
  input wire logic [2:0] sync_zero_rate_code,
  input wire logic sync_zero_known,
  input wire logic sync_zero_failed_flag,
  input wire logic [OFS_W-1:0] ref_zero_offset,
  input wire logic [OFS_W-1:0] ref_one_offset,
  input wire logic [OFS_W-1:0] ref_two_offset,
  input wire logic [OFS_W-1:0] ref_three_offset,
  input wire logic [OFS_W-1:0] ref_four_offset,
  output logic [2:0] input_zero_range_limit,
  output logic [2:0] input_one_range_limit,
  output logic [2:0] input_two_range_limit,
  output logic [2:0] input_three_range_limit,
  output logic [2:0] input_four_range_limit,
  output logic [4:0] ref_out_of_range
);

  localparam int NUM_REFS = 5;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  logic sck_s;
  logic cs_n_s;
  logic mosi_s;
  logic sck_d_r;

  // idle levels: clock low, select high, data low
  bit_sync #(.WIDTH(3)) u_pin_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({spi_sck, spi_cs_n, spi_mosi}),
    .rst_val(3'h2),
    .sync_out({sck_s, cs_n_s, mosi_s})
  );

  // third stage only for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  logic sck_rise;
  logic sck_fall;
  assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s;

  // ****************************************************************
  // status capture
  // ****************************************************************

  logic [3:0] ref_code [NUM_REFS];
  logic [3:0] ref_shown [NUM_REFS];
  logic [OFS_W-1:0] ref_offset [NUM_REFS];
  logic [2:0] range_sel [NUM_REFS];
  logic [NUM_REFS-1:0] oor_flag;

  assign ref_code[0] = input_zero_rate_code;
  assign ref_code[1] = input_one_rate_code;
  assign ref_code[2] = input_two_rate_code;
  assign ref_code[3] = input_three_rate_code;
  assign ref_code[4] = input_four_rate_code;
  assign ref_offset[0] = ref_zero_offset;
  assign ref_offset[1] = ref_one_offset;
  assign ref_offset[2] = ref_two_offset;
  assign ref_offset[3] = ref_three_offset;
  assign ref_offset[4] = ref_four_offset;

  logic [7:0] range_ctrl_a_r;
  logic [7:0] range_ctrl_b_r;
  logic [7:0] range_ctrl_c_r;

  // limit fields as the monitors see them
  assign range_sel[0] = range_ctrl_a_r[LOW_FIELD_LSB +: 3];
  assign range_sel[1] = range_ctrl_a_r[HIGH_FIELD_LSB +: 3];
  assign range_sel[2] = range_ctrl_b_r[LOW_FIELD_LSB +: 3];
  assign range_sel[3] = range_ctrl_b_r[HIGH_FIELD_LSB +: 3];
  assign range_sel[4] = range_ctrl_c_r[LOW_FIELD_LSB +: 3];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REFS; gi++) begin : g_ref
      // a code outside the defined set is treated as not yet recognised
      assign ref_shown[gi] = (ref_rate_known[gi] && ref_code[gi] <= REF_RATE_77M76) ?
        ref_code[gi] : REF_RATE_UNKNOWN;

      range_monitor u_mon (
        .sys_clk(sys_clk),
        .srst(srst),
        .offset_mag(ref_offset[gi]),
        .limit_sel(range_sel[gi]),
        .out_of_range_r(oor_flag[gi])
      );
    end
  endgenerate

  logic [7:0] status_a_r;
  logic [7:0] status_b_r;
  logic [7:0] status_c_r;
  logic [7:0] sync_status_r;
  logic [2:0] sync_shown;

  // an unknown sync rate is forced to the reserved code
  assign sync_shown = sync_zero_known ? sync_zero_rate_code : SYNC_RATE_UNKNOWN;

  // status bytes refreshed every cycle so a read sees a clean snapshot
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_a_r <= {REF_RATE_UNKNOWN, REF_RATE_UNKNOWN};
      status_b_r <= {REF_RATE_UNKNOWN, REF_RATE_UNKNOWN};
      status_c_r <= {4'h0, REF_RATE_UNKNOWN};
      sync_status_r <= {5'h00, SYNC_RATE_UNKNOWN};
    end else begin
      status_a_r <= {ref_shown[1], ref_shown[0]};
      status_b_r <= {ref_shown[3], ref_shown[2]};
      status_c_r <= {4'h0, ref_shown[4]};
      sync_status_r <= {4'h0, sync_zero_failed_flag, sync_shown};
    end
  end

  // ****************************************************************
  // read data selection
  // ****************************************************************

  function automatic logic [7:0] read_mux(input logic [6:0] addr);
    logic [7:0] val;
    val = UNMAPPED_READ_VAL;
    if (addr == REF_RATE_STATUS_A_OFS) begin
      val = status_a_r;
    end else if (addr == REF_RATE_STATUS_B_OFS) begin
      val = status_b_r;
    end else if (addr == REF_RATE_STATUS_C_OFS) begin
      val = status_c_r;
    end else if (addr == SYNC_ZERO_RATE_STATUS_OFS) begin
      val = sync_status_r;
    end else if (addr == RANGE_LIMIT_CTRL_A_OFS) begin
      val = range_ctrl_a_r;
    end else if (addr == RANGE_LIMIT_CTRL_B_OFS) begin
      val = range_ctrl_b_r;
    end else if (addr == RANGE_LIMIT_CTRL_C_OFS) begin
      val = range_ctrl_c_r;
    end
    return val;
  endfunction

  // ****************************************************************
  // serial frame engine
  // ****************************************************************

  spi_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic [6:0] addr_r;
  logic is_read_r;
  logic [7:0] byte_in;
  logic byte_done;

  assign byte_in = {shift_r, mosi_s};
  assign byte_done = sck_rise && (bit_cnt_r == LAST_BIT_IDX);

  // command byte then data bytes; the address steps after each data byte
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= spi_idle;
      bit_cnt_r <= 3'h0;
      shift_r <= 7'h00;
      addr_r <= 7'h00;
      is_read_r <= 1'b0;
    end else if (cs_n_s) begin
      state_r <= spi_idle;
      bit_cnt_r <= 3'h0;
    end else begin
      if (sck_rise) begin
        shift_r <= byte_in[6:0];
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      case (state_r)
        spi_idle: begin
          state_r <= spi_addr;
        end
        spi_addr: begin
          if (byte_done) begin
            is_read_r <= byte_in[CMD_READ_BIT];
            addr_r <= byte_in[6:0];
            state_r <= spi_data;
          end
        end
        spi_data: begin
          if (byte_done) begin
            addr_r <= addr_r + 7'h01;
          end
        end
        default: begin
          state_r <= spi_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************

  logic wr_en;
  assign wr_en = !cs_n_s && (state_r == spi_data) && byte_done && !is_read_r;

  // reserved bits are stored as written so read-back returns the byte last written
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      range_ctrl_a_r <= RANGE_LIMIT_CTRL_RST;
      range_ctrl_b_r <= RANGE_LIMIT_CTRL_RST;
      range_ctrl_c_r <= RANGE_LIMIT_CTRL_RST;
    end else if (wr_en) begin
      if (addr_r == RANGE_LIMIT_CTRL_A_OFS) begin
        range_ctrl_a_r <= byte_in;
      end else if (addr_r == RANGE_LIMIT_CTRL_B_OFS) begin
        range_ctrl_b_r <= byte_in;
      end else if (addr_r == RANGE_LIMIT_CTRL_C_OFS) begin
        range_ctrl_c_r <= byte_in;
      end
    end
  end

  // ****************************************************************
  // read return path
  // ****************************************************************

  logic [7:0] tx_r;
  logic [7:0] rd_val;
  logic load_first;
  logic load_next;

  assign load_first = !cs_n_s && (state_r == spi_addr) && byte_done && byte_in[CMD_READ_BIT];
  assign load_next = !cs_n_s && (state_r == spi_data) && byte_done && is_read_r;
  // one lookup serves the command byte and every following data byte
  assign rd_val = read_mux(load_first ? byte_in[6:0] : addr_r + 7'h01);

  // first bit is put out before the first data clock rises
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_r <= 8'h00;
      spi_miso <= 1'b0;
    end else if (load_first || load_next) begin
      tx_r <= rd_val;
      spi_miso <= rd_val[7];
    end else if (sck_fall && is_read_r && state_r == spi_data && bit_cnt_r != 3'h0) begin
      // the fall after a byte's last rise is skipped so the new msb stays put
      tx_r <= {tx_r[6:0], 1'b0};
      spi_miso <= tx_r[6];
    end
  end

  // data out only driven during the data phase of a read frame
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spi_miso_oe_n <= 1'b1;
    end else if (cs_n_s) begin
      spi_miso_oe_n <= 1'b1;
    end else if (load_first) begin
      spi_miso_oe_n <= 1'b0;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************

  // limit selects leave on flops so the monitoring logic sees clean levels
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      input_zero_range_limit <= RANGE_LIMIT_CTRL_RST[2:0];
      input_one_range_limit <= RANGE_LIMIT_CTRL_RST[2:0];
      input_two_range_limit <= RANGE_LIMIT_CTRL_RST[2:0];
      input_three_range_limit <= RANGE_LIMIT_CTRL_RST[2:0];
      input_four_range_limit <= RANGE_LIMIT_CTRL_RST[2:0];
    end else begin
      input_zero_range_limit <= range_sel[0];
      input_one_range_limit <= range_sel[1];
      input_two_range_limit <= range_sel[2];
      input_three_range_limit <= range_sel[3];
      input_four_range_limit <= range_sel[4];
    end
  end

  // one extra stage, so the flags trail the limit outputs by one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ref_out_of_range <= '0;
    end else begin
      ref_out_of_range <= oor_flag;
    end
  end

endmodule

// file: verification/ref_freq_status_monitor.sv
// port assertions for the rate status and range limit bank
`timescale 1ns/100ps
module ref_freq_status_monitor
  import freq_status_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n,
  input wire logic [OFS_W-1:0] ref_zero_offset,
  input wire logic [OFS_W-1:0] ref_four_offset,
  input wire logic [2:0] input_zero_range_limit,
  input wire logic [2:0] input_four_range_limit,
  input wire logic [4:0] ref_out_of_range
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_LIMIT_RESET: assert property ($fell(srst) |-> input_zero_range_limit == 3'h3
    && input_four_range_limit == 3'h3) else $error("limit select not 011 after reset");
  AST_OOR_RESET: assert property ($fell(srst) |-> ref_out_of_range == 5'h00
    && spi_miso_oe_n) else $error("flags or miso enable wrong after reset");
  AST_LIMIT_CSLOW: assert property ($changed(input_zero_range_limit) |->
    !$past(spi_cs_n)) else $error("limit select changed outside a frame");
  AST_OOR_SET_ZERO: assert property ((ref_zero_offset >
    RANGE_UPPER[input_zero_range_limit]) [*3] |=> ref_out_of_range[0])
    else $error("flag zero not set above upper limit");
  AST_OOR_CLR_FOUR: assert property ((ref_four_offset <
    RANGE_LOWER[input_four_range_limit]) [*3] |=> !ref_out_of_range[4])
    else $error("flag four not cleared below lower limit");
  AST_OOR_HOLD_ZERO: assert property ((ref_zero_offset >= RANGE_LOWER[input_zero_range_limit]
    && ref_zero_offset <= RANGE_UPPER[input_zero_range_limit]) [*3]
    |=> $stable(ref_out_of_range[0])) else $error("flag zero moved inside band");
  AST_OE_IDLE: assert property (spi_cs_n [*4] |-> spi_miso_oe_n)
    else $error("miso driven without a frame");
  AST_MISO_STABLE: assert property (!spi_miso_oe_n && spi_sck [*7] |-> $stable(spi_miso))
    else $error("miso changed while clock high");
  AST_OE_RELEASE: assert property ($rose(spi_cs_n) |-> ##[1:5] spi_miso_oe_n)
    else $error("miso not released after frame end");
endmodule
bind ref_freq_detect_range_status ref_freq_status_monitor mon (.sys_clk(sys_clk),
  .srst(srst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
  .spi_miso_oe_n(spi_miso_oe_n), .ref_zero_offset(ref_zero_offset),
  .ref_four_offset(ref_four_offset), .input_zero_range_limit(input_zero_range_limit),
  .input_four_range_limit(input_four_range_limit), .ref_out_of_range(ref_out_of_range));

// file: verification/spi_host_model.sv
// host side of the serial configuration port, mode 0, msb first
`timescale 1ns/100ps
module spi_host_model (
  input wire logic sys_clk,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n,
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // ****************************************************************
  // one frame: command byte then nb data bits; half sets the pace
  // ****************************************************************
  // a partial last byte is allowed on purpose, the device must drop it
  task automatic frame(input logic rw, input logic [6:0] adr, input logic [7:0] wd [9],
      input int nb, input int half, output logic [7:0] rd [9]);
    logic [7:0] cmd;
    cmd = {rw, adr};
    spi_cs_n <= 1'b0;
    repeat (half) @(posedge sys_clk);
    for (int i = 0; i < nb + 8; i++) begin
      spi_mosi <= (i < 8) ? cmd[7 - i] : wd[i / 8 - 1][7 - i % 8];
      repeat (half) @(posedge sys_clk);
      spi_sck <= 1'b1;
      // sampled on the rise; an undriven line reads as the inverse
      if (i >= 8) rd[i / 8 - 1][7 - i % 8] = spi_miso_oe_n ? ~spi_miso : spi_miso;
      repeat (half) @(posedge sys_clk);
      spi_sck <= 1'b0;
    end
    repeat (half) @(posedge sys_clk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi; // released line shows no stale value
    repeat (half) @(posedge sys_clk);
  endtask
endmodule

// file: verification/tb_ref_freq_detect_range_status.sv
// self-checking bench for the rate status and range limit bank
`timescale 1ns/100ps
module tb_ref_freq_detect_range_status;
  import freq_status_pkg::*;
  logic sys_clk, srst, sck, cs_n, mosi, miso, miso_oe_n, sknown, sfail;
  logic [3:0] rc [5];
  logic [4:0] known, oor;
  logic [2:0] scode;
  logic [2:0] lim [5];
  logic [11:0] ofs [5];
  logic [7:0] wd [9];
  logic [7:0] rd [9];
  logic [7:0] ctrl [3];
  int up [8] = '{120, 520, 1300, 830, 180, 320, 475, 675};
  int lo [8] = '{92, 400, 1000, 640, 138, 246, 366, 520};
  int miscompares, n_compared, cycles, seed;
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  spi_host_model host (.sys_clk(sys_clk), .spi_miso(miso), .spi_miso_oe_n(miso_oe_n),
    .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi));
  ref_freq_detect_range_status dut (.sys_clk(sys_clk), .srst(srst), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(miso_oe_n),
    .input_zero_rate_code(rc[0]), .input_one_rate_code(rc[1]), .input_two_rate_code(rc[2]),
    .input_three_rate_code(rc[3]), .input_four_rate_code(rc[4]), .ref_rate_known(known),
    .sync_zero_rate_code(scode), .sync_zero_known(sknown), .sync_zero_failed_flag(sfail),
    .ref_zero_offset(ofs[0]), .ref_one_offset(ofs[1]), .ref_two_offset(ofs[2]),
    .ref_three_offset(ofs[3]), .ref_four_offset(ofs[4]), .input_zero_range_limit(lim[0]),
    .input_one_range_limit(lim[1]), .input_two_range_limit(lim[2]),
    .input_three_range_limit(lim[3]), .input_four_range_limit(lim[4]),
    .ref_out_of_range(oor));
  // ****************************************************************
  // reference model and comparison
  // ****************************************************************
  function automatic logic [3:0] rexp(int i);
    return (known[i] && rc[i] <= 4'hA) ? rc[i] : 4'hF;
  endfunction
  function automatic logic [7:0] sexp(int a);
    case (a)
      16: return {rexp(1), rexp(0)};
      17: return {rexp(3), rexp(2)};
      18: return {4'h0, rexp(4)};
      20: return {4'h0, sfail, sknown ? scode : 3'h6};
      22, 23, 24: return ctrl[a - 22];
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // reserved upper nibbles of status bytes are ignored by software
  task automatic rd_chk(input int half);
    logic [7:0] m;
    host.frame(1'b1, 7'h10, wd, 72, half, rd);
    for (int k = 0; k < 9; k++) begin
      m = (k == 2 || k == 4) ? 8'h0F : 8'hFF;
      chk(rd[k] & m, sexp(16 + k) & m);
    end
  endtask
  task automatic lim_chk();
    for (int i = 0; i < 5; i++) begin
      chk({5'h0, lim[i]}, (i < 4) ? (ctrl[i / 2] >> (4 * (i % 2))) & 8'h07 : ctrl[2] & 8'h07);
    end
  endtask
  task automatic wr_ctrl(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c,
      input logic [2:0] d, input logic [2:0] e, input int half);
    ctrl[0] = {1'b0, b, 1'b0, a};
    ctrl[1] = {1'b0, d, 1'b0, c};
    ctrl[2] = {4'h3, 1'b0, e};
    wd[0] = ctrl[0];
    wd[1] = ctrl[1];
    wd[2] = ctrl[2];
    host.frame(1'b0, 7'h16, wd, 24, half, rd);
  endtask
  task automatic reset_dut();
    srst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    ctrl = '{8'h33, 8'h33, 8'h33};
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************************************
  // stimulus
  // ****************************************************************
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    srst = 1'b1;
    known = 5'h00;
    scode = 3'h0;
    sknown = 1'b0;
    sfail = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rc[i] = 4'h0;
      ofs[i] = 12'h000;
    end
    for (int i = 0; i < 9; i++) wd[i] = 8'h00;
    seed = $urandom(70221);
    reset_dut();
    rd_chk(5);
    lim_chk();
    // random status inputs, codes above 1010 included, and random selects
    for (int n = 0; n < 6; n++) begin
      for (int i = 0; i < 5; i++) rc[i] <= 4'($urandom);
      known <= 5'($urandom);
      scode <= 3'($urandom);
      sknown <= 1'($urandom);
      sfail <= 1'($urandom);
      wr_ctrl(3'($urandom), 3'($urandom), 3'($urandom), 3'($urandom), 3'($urandom), 5 + 3 * (n % 2));
      lim_chk();
      rd_chk(5 + 3 * (n % 2));
    end
    // writes to status and unmapped places refused; a full byte lands, the cut one is dropped
    wd[0] = 8'h25;
    wd[1] = 8'h5A;
    host.frame(1'b0, 7'h10, wd, 16, 5, rd);
    host.frame(1'b0, 7'h13, wd, 8, 5, rd);
    host.frame(1'b0, 7'h16, wd, 13, 5, rd);
    ctrl[0] = wd[0];
    rd_chk(8);
    lim_chk();
    reset_dut();
    lim_chk();
    // hysteresis at each limit pair: set above upper, hold in band, clear below lower
    for (int s = 0; s < 8; s++) begin
      wr_ctrl(3'(s), 3'(s), 3'(s), 3'(s), 3'(s), 5);
      for (int p = 0; p < 5; p++) begin
        for (int i = 0; i < 5; i++) begin
          ofs[i] <= 12'((p == 0) ? up[s] + 1 : (p == 1) ? (up[s] + lo[s]) / 2
            : (p == 2) ? lo[s] : (p == 3) ? lo[s] - 1 : up[s]);
        end
        repeat (4) @(posedge sys_clk);
        chk({3'h0, oor}, (p < 3) ? 8'h1F : 8'h00);
      end
    end
    complete_run();
  end
endmodule
